// *** afd_decoder.sv ***
// Purpose: Decodes an alpha-field byte string into 16-bit characters
// Assumes: Bytes from same-clock record reader; IN_LAST marks final byte
// Notes: Characters pass through an 8-word FIFO to a registered output
// Notes on behaviour
// - Lead byte 80 means each following byte pair up to an FFFF pair is one 16-bit character.
// - In pair scheme the earlier byte is the high half; first char bytes 2,3.
// - Pair scheme padding is FF; an odd trailing byte is never decoded.
// - Lead byte 81: second byte gives the number of characters.
// - Scheme 81 base pointer is third byte shifted left seven, other bits zero.
// - Counted byte with top bit clear is a 7-bit default-alphabet character.
// - Counted byte with top bit set adds low seven bits to base pointer.
// - Lead byte 82: count in byte two, full base from bytes three, four.
// - Scheme 82 characters start at byte five, coded like scheme 81.
// - FF inside the declared count decodes as base plus 7F.
// - One record uses exactly one coding scheme throughout.
// - All three 16-bit schemes are always supported.
`timescale 1ns/1ps
`default_nettype none
`include "afd_defines.svh"
module afd_decoder
	import afd_pkg::*;
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic IN_VALID,
	input wire logic [7:0] IN_DATA,
	input wire logic IN_LAST,
	output logic IN_READY,
	output logic OUT_VALID,
	input wire logic OUT_READY,
	output logic [15:0] OUT_CHAR,
	output logic OUT_UCS2,
	output logic OUT_UNCONV,
	output logic OUT_DONE
);
	afd_state_t state;
	afd_state_t next_state;
	afd_scheme_t scheme;
	afd_scheme_t next_scheme;
	logic [7:0] chars_left;
	logic [7:0] next_left;
	logic [15:0] base;
	logic [15:0] next_base;
	logic [7:0] hi_byte;
	logic [7:0] next_hi;
	logic pending_done;
	logic next_pending;
	logic accept;
	logic wr_valid;
	logic wr_ready;
	logic wr_done;
	logic wr_ucs2;
	logic wr_unconv;
	logic [15:0] wr_char;
	logic [15:0] map_char;
	logic map_ucs2;
	logic rd_valid;
	logic rd_ready;
	logic [`AFD_ENTRY_W-1:0] rd_data;
	logic [`AFD_FIFO_LVL_W-1:0] fifo_level;

	assign accept = IN_VALID && IN_READY;

	afd_charmap u_charmap (
		.code(IN_DATA),
		.base(base),
		.char_out(map_char),
		.is_ucs2(map_ucs2)
	);

	afd_fifo #(
		.WIDTH(`AFD_ENTRY_W),
		.DEPTH(`AFD_FIFO_DEPTH)
	) u_fifo (
		.clk(CLK),
		.rst(RST),
		.in_valid(wr_valid),
		.in_ready(wr_ready),
		.in_data({wr_done, wr_unconv, wr_ucs2, wr_char}),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data(rd_data),
		.level(fifo_level)
	);

	// Decode step for one accepted byte
	always_comb begin
		next_state = state;
		next_scheme = scheme;
		next_left = chars_left;
		next_base = base;
		next_hi = hi_byte;
		next_pending = pending_done;
		wr_valid = 1'b0;
		wr_done = 1'b0;
		wr_ucs2 = 1'b0;
		wr_unconv = 1'b0;
		wr_char = 16'h0000;
		if (pending_done) begin
			wr_valid = 1'b1;
			wr_done = 1'b1;
			if (wr_ready) begin
				next_pending = 1'b0;
			end
		end else if (accept) begin
			unique case (state)
				ST_LEAD: begin
					unique case (IN_DATA)
						`AFD_LEAD_PAIRS: begin
							next_scheme = SCH_PAIRS;
							next_state = ST_PAIR_HI;
						end
						`AFD_LEAD_HALF: begin
							next_scheme = SCH_HALF;
							next_state = ST_COUNT;
						end
						`AFD_LEAD_FULL: begin
							next_scheme = SCH_FULL;
							next_state = ST_COUNT;
						end
						default: begin
							next_scheme = SCH_NONE;
							next_state = ST_RAW;
							wr_valid = 1'b1;
							wr_unconv = 1'b1;
							wr_char = {8'h00, IN_DATA};
						end
					endcase
				end
				ST_COUNT: begin
					next_left = IN_DATA;
					next_state = ST_BASE_HI;
				end
				ST_BASE_HI: begin
					if (scheme == SCH_HALF) begin
						next_base = {1'b0, IN_DATA, 7'h00};
						next_state = ST_CHARS;
					end else begin
						next_base = {IN_DATA, base[7:0]};
						next_state = ST_BASE_LO;
					end
				end
				ST_BASE_LO: begin
					next_base = {base[15:8], IN_DATA};
					next_state = ST_CHARS;
				end
				ST_CHARS: begin
					if (chars_left != 8'h00) begin
						wr_valid = 1'b1;
						wr_char = map_char;
						wr_ucs2 = map_ucs2;
						next_left = chars_left - 8'h01;
					end else begin
						next_state = ST_SKIP;
					end
				end
				ST_PAIR_HI: begin
					next_hi = IN_DATA;
					next_state = ST_PAIR_LO;
				end
				ST_PAIR_LO: begin
					if ({hi_byte, IN_DATA} == `AFD_PAD_PAIR) begin
						next_state = ST_SKIP;
					end else begin
						wr_valid = 1'b1;
						wr_ucs2 = 1'b1;
						wr_char = {hi_byte, IN_DATA};
						next_state = ST_PAIR_HI;
					end
				end
				ST_RAW: begin
					wr_valid = 1'b1;
					wr_unconv = 1'b1;
					wr_char = {8'h00, IN_DATA};
				end
				ST_SKIP: begin
					next_state = ST_SKIP;
				end
			endcase
			if (IN_LAST) begin
				next_state = ST_LEAD;
				if (wr_valid) begin
					next_pending = 1'b1;
				end else begin
					wr_valid = 1'b1;
					wr_done = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			state <= ST_LEAD;
			scheme <= SCH_NONE;
			pending_done <= 1'b0;
		end else begin
			state <= next_state;
			scheme <= next_scheme;
			pending_done <= next_pending;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			chars_left <= 8'h00;
			base <= 16'h0000;
			hi_byte <= 8'h00;
		end else begin
			chars_left <= next_left;
			base <= next_base;
			hi_byte <= next_hi;
		end
	end

	// Input throttle keeps room for one more write after a late ready
	always_ff @(posedge CLK) begin
		if (RST) begin
			IN_READY <= 1'b0;
		end else begin
			IN_READY <= (fifo_level < `AFD_READY_LVL) && !next_pending;
		end
	end

	// Registered output stage
	// Idle cycle after a done entry keeps back-to-back done pulses apart
	assign rd_ready = (!OUT_VALID || OUT_READY) && !OUT_DONE;

	always_ff @(posedge CLK) begin
		if (RST) begin
			OUT_VALID <= 1'b0;
			OUT_DONE <= 1'b0;
			OUT_CHAR <= 16'h0000;
			OUT_UCS2 <= 1'b0;
			OUT_UNCONV <= 1'b0;
		end else begin
			OUT_DONE <= 1'b0;
			if (rd_valid && rd_ready) begin
				OUT_VALID <= !rd_data[`AFD_ENTRY_DONE];
				OUT_DONE <= rd_data[`AFD_ENTRY_DONE];
				OUT_CHAR <= rd_data[`AFD_ENTRY_CHAR_HI:0];
				OUT_UCS2 <= rd_data[`AFD_ENTRY_UCS2];
				OUT_UNCONV <= rd_data[`AFD_ENTRY_UNCONV];
			end else if (OUT_READY) begin
				OUT_VALID <= 1'b0;
			end
		end
	end

	// Last byte taken, for the pair check
	logic [7:0] taken_byte;

	always_ff @(posedge CLK) begin
		if (accept) begin
			taken_byte <= IN_DATA;
		end
	end

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);

	sequence lead_taken(logic [7:0] code);
		accept && !pending_done && state == ST_LEAD && IN_DATA == code && !IN_LAST;
	endsequence

	sequence last_taken;
		accept && !pending_done && IN_LAST;
	endsequence

	sequence char_byte_taken;
		accept && !pending_done && state == ST_CHARS && chars_left != 8'h00;
	endsequence

	lead_pairs_a: assert property (lead_taken(`AFD_LEAD_PAIRS) |=>
		state == ST_PAIR_HI && scheme == SCH_PAIRS)
		else $error("Pair lead did not start pair decoding");

	pair_order_a: assert property (accept && !pending_done && state == ST_PAIR_LO
		&& {hi_byte, IN_DATA} != `AFD_PAD_PAIR |-> wr_valid && wr_ucs2
		&& wr_char == {taken_byte, IN_DATA})
		else $error("Pair character not formed high byte first");

	pad_pair_a: assert property (accept && !pending_done && state == ST_PAIR_LO
		&& {hi_byte, IN_DATA} == `AFD_PAD_PAIR |-> !(wr_valid && !wr_done))
		else $error("Padding pair was decoded as a character");

	odd_byte_a: assert property (accept && !pending_done && state == ST_PAIR_HI
		&& IN_LAST |-> wr_valid && wr_done && !wr_ucs2)
		else $error("Odd trailing byte was decoded");

	count_load_a: assert property (accept && !pending_done && state == ST_COUNT
		&& !IN_LAST |=> chars_left == $past(IN_DATA) && state == ST_BASE_HI)
		else $error("Character count not taken from second byte");

	half_base_a: assert property (accept && !pending_done && state == ST_BASE_HI
		&& scheme == SCH_HALF && !IN_LAST |=> base[15] == 1'b0 && base[6:0] == 7'h00
		&& base[14:7] == $past(IN_DATA) && state == ST_CHARS)
		else $error("Half-page base pointer wrongly formed");

	alpha7_char_a: assert property (char_byte_taken and IN_DATA[7] == 1'b0
		|-> wr_valid && !wr_ucs2 && wr_char == {9'h000, IN_DATA[6:0]})
		else $error("Default alphabet character wrongly emitted");

	offset_char_a: assert property (char_byte_taken and IN_DATA[7] == 1'b1
		|-> wr_valid && wr_ucs2 && wr_char == base + {9'h000, IN_DATA[6:0]})
		else $error("Offset character not base plus offset");

	full_base_hi_a: assert property (accept && !pending_done && state == ST_BASE_HI
		&& scheme == SCH_FULL && !IN_LAST
		|=> base[15:8] == $past(IN_DATA) && state == ST_BASE_LO)
		else $error("Full base pointer high byte not from third byte");

	full_base_a: assert property (accept && !pending_done && state == ST_BASE_LO
		&& scheme == SCH_FULL && !IN_LAST |=> base == {$past(base[15:8]), $past(IN_DATA)}
		&& state == ST_CHARS)
		else $error("Full base pointer or fifth-byte start wrong");

	pad_in_count_a: assert property (char_byte_taken and IN_DATA == `AFD_PAD_BYTE
		|-> wr_valid && wr_ucs2 && wr_char == base + 16'h007f)
		else $error("Padding value inside count not decoded");

	count_spent_a: assert property (accept && !pending_done && state == ST_CHARS
		&& chars_left == 8'h00 |-> !(wr_valid && !wr_done))
		else $error("Character emitted beyond declared count");

	one_scheme_a: assert property (state != ST_LEAD && $past(state) != ST_LEAD
		|-> $stable(scheme))
		else $error("Coding scheme changed inside a record");

	raw_pass_a: assert property (accept && !pending_done && state == ST_LEAD
		&& IN_DATA != `AFD_LEAD_PAIRS && IN_DATA != `AFD_LEAD_HALF
		&& IN_DATA != `AFD_LEAD_FULL |-> wr_valid && wr_unconv && !wr_ucs2
		&& wr_char == {8'h00, IN_DATA})
		else $error("Unknown lead byte not passed through");

	done_queued_a: assert property (last_taken |-> (wr_valid && wr_done)
		or ##1 pending_done)
		else $error("Done marker not queued after last byte");

	done_pulse_a: assert property (OUT_DONE |-> !OUT_VALID ##1 !OUT_DONE)
		else $error("Done indication not a lone one-cycle pulse");

	out_hold_a: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID
		&& $stable(OUT_CHAR) && $stable(OUT_UCS2) && $stable(OUT_UNCONV))
		else $error("Output character dropped while stalled");

	room_a: assert property (wr_valid && !wr_done |-> wr_ready)
		else $error("Character written into a full buffer");

endmodule : afd_decoder
`default_nettype wire

// *** afd_defines.svh ***
// Purpose: Constants for the alpha-field text decoder
// Assumes: Included by bare name from the decoder module only
// Notes: Lead codes, padding value, entry layout and buffer depth
`ifndef AFD_DEFINES_SVH
`define AFD_DEFINES_SVH

`define AFD_LEAD_PAIRS 8'h80
`define AFD_LEAD_HALF 8'h81
`define AFD_LEAD_FULL 8'h82
`define AFD_PAD_BYTE 8'hff
`define AFD_PAD_PAIR 16'hffff
`define AFD_CHAR_W 16
`define AFD_ENTRY_W 19
`define AFD_ENTRY_CHAR_HI 15
`define AFD_ENTRY_UCS2 16
`define AFD_ENTRY_UNCONV 17
`define AFD_ENTRY_DONE 18
`define AFD_FIFO_DEPTH 8
`define AFD_FIFO_LVL_W 4
`define AFD_READY_LVL 4'h7

`endif

// *** afd_pkg.sv ***
// Purpose: Types shared by the alpha-field text decoder
// Assumes: Compiled before the decoder modules
// Notes: States and coding schemes
package afd_pkg;

	typedef enum logic [3:0] {
		ST_LEAD,
		ST_COUNT,
		ST_BASE_HI,
		ST_BASE_LO,
		ST_CHARS,
		ST_PAIR_HI,
		ST_PAIR_LO,
		ST_RAW,
		ST_SKIP
	} afd_state_t;

	typedef enum logic [1:0] {
		SCH_NONE,
		SCH_PAIRS,
		SCH_HALF,
		SCH_FULL
	} afd_scheme_t;

endpackage : afd_pkg

// *** afd_fifo.sv ***
// Purpose: Flip-flop FIFO with valid and ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes: Level output lets the writer throttle ahead of full
`timescale 1ns/1ps
`default_nettype none
module afd_fifo #(
	parameter int WIDTH = 19,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic push;
	logic pop;

	assign in_ready = (level != (AW+1)'(DEPTH));
	assign out_valid = (level != '0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				level <= level + 1'b1;
			end else if (pop && !push) begin
				level <= level - 1'b1;
			end
		end
	end
endmodule : afd_fifo
`default_nettype wire

// *** afd_charmap.sv ***
// Purpose: Maps one counted-scheme byte to a character
// Assumes: Base pointer already assembled
// Notes: Bit 7 set selects base plus offset, else default alphabet
`timescale 1ns/1ps
`default_nettype none
module afd_charmap (
	input wire logic [7:0] code,
	input wire logic [15:0] base,
	output logic [15:0] char_out,
	output logic is_ucs2
);
	assign is_ucs2 = code[7];
	assign char_out = code[7] ? base + {9'h000, code[6:0]} : {9'h000, code[6:0]};
endmodule : afd_charmap
`default_nettype wire

// *** afd_partner.sv ***
// Purpose: Record reader and text consumer facing the decoder
// Assumes: Bench fills txq with {last, byte}; rxq collects characters
// Notes: Idle data line toggles; consumer stalls at stall_pct percent
`timescale 1ns/1ps
`default_nettype none
module afd_partner (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_ready,
	input wire logic out_valid,
	input wire logic [15:0] out_char,
	input wire logic out_ucs2,
	input wire logic out_unconv,
	input wire logic out_done,
	output logic in_valid,
	output logic [7:0] in_data,
	output logic in_last,
	output logic out_ready
);
	logic [8:0] txq[$];
	logic [17:0] rxq[$];
	int stall_pct = 0;
	int n_done = 0;
	always @(posedge clk) begin
		if (rst) begin
			in_valid <= 1'b0;
			in_data <= 8'h00;
			in_last <= 1'b0;
			out_ready <= 1'b0;
		end else begin
			if (out_valid && out_ready) begin
				rxq.push_back({out_unconv, out_ucs2, out_char});
			end
			if (out_done) begin
				n_done++;
			end
			out_ready <= ($urandom % 100) >= stall_pct;
			if (!in_valid || in_ready) begin
				if (txq.size() > 0) begin
					{in_last, in_data} <= txq.pop_front();
					in_valid <= 1'b1;
				end else begin
					in_valid <= 1'b0;
					in_last <= 1'b0;
					in_data <= ~in_data;
				end
			end
		end
	end
endmodule : afd_partner
`default_nettype wire

// *** alpha_field_ucs2_decoder_test.sv ***
// Purpose: Self-checking bench for the alpha-field decoder
// Assumes: Partner model drives bytes and takes characters
// Notes: Fixed corner records, then random records under stall, then random records with no stall
`timescale 1ns/1ps
`default_nettype none
module test_alpha_field_ucs2_decoder;
	import afd_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic in_valid, in_last, in_ready, out_valid, out_ready, out_ucs2, out_unconv, out_done;
	logic [7:0] in_data;
	logic [15:0] out_char;
	logic [7:0] rec[$];
	logic [17:0] exp_q[$];
	int n_mismatch = 0;
	int n_tests = 0;
	int cyc = 0;
	int n_rec = 0;
	logic blocked = 1'b0;
	always #4 clk = ~clk;
	afd_decoder dut (.CLK(clk), .RST(rst), .IN_VALID(in_valid), .IN_DATA(in_data),
		.IN_LAST(in_last), .IN_READY(in_ready), .OUT_VALID(out_valid), .OUT_READY(out_ready),
		.OUT_CHAR(out_char), .OUT_UCS2(out_ucs2), .OUT_UNCONV(out_unconv), .OUT_DONE(out_done));
	afd_partner partner (.clk(clk), .rst(rst), .in_ready(in_ready), .out_valid(out_valid),
		.out_char(out_char), .out_ucs2(out_ucs2), .out_unconv(out_unconv),
		.out_done(out_done), .in_valid(in_valid), .in_data(in_data), .in_last(in_last),
		.out_ready(out_ready));
	task finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : finish_test
	task chk(input logic [17:0] seen, input logic [17:0] expv);
		n_tests++;
		if (seen !== expv) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
		end
	endtask : chk
	function automatic void expect_rec();
		int n;
		int first;
		logic [15:0] base;
		case (rec[0])
			8'h80: begin
				for (int i = 1; i + 1 < rec.size(); i += 2) begin
					if ({rec[i], rec[i+1]} == 16'hffff) break;
					exp_q.push_back({2'b01, rec[i], rec[i+1]});
				end
			end
			8'h81, 8'h82: begin
				n = rec[1];
				base = (rec[0] == 8'h81) ? {1'b0, rec[2], 7'h00} : {rec[2], rec[3]};
				first = (rec[0] == 8'h81) ? 3 : 4;
				for (int i = 0; i < n && first + i < rec.size(); i++) begin
					if (rec[first+i][7]) exp_q.push_back({2'b01, base + rec[first+i][6:0]});
					else exp_q.push_back({2'b00, 9'h000, rec[first+i][6:0]});
				end
			end
			default: foreach (rec[i]) exp_q.push_back({2'b10, 8'h00, rec[i]});
		endcase
	endfunction : expect_rec
	task send();
		foreach (rec[i]) partner.txq.push_back({i == rec.size() - 1, rec[i]});
		expect_rec();
		n_rec++;
		rec.delete();
	endtask : send
	task drain(input string name);
		while (partner.n_done < n_rec) @(posedge clk);
		repeat (4) @(posedge clk);
		chk(18'(partner.rxq.size()), 18'(exp_q.size()));
		while (partner.rxq.size() > 0 && exp_q.size() > 0) begin
			chk(partner.rxq.pop_front(), exp_q.pop_front());
		end
		partner.rxq.delete();
		exp_q.delete();
		$display("test %s done", name);
	endtask : drain
	task rand_rec();
		int k;
		logic [7:0] lead;
		k = $urandom % 7;
		case ($urandom % 4)
			0: lead = 8'h80;
			1: lead = 8'h81;
			2: lead = 8'h82;
			default: lead = 8'(($urandom % 8'h7f));
		endcase
		rec.push_back(lead);
		if (lead == 8'h81 || lead == 8'h82) begin
			rec.push_back(8'(k));
			rec.push_back(8'($urandom));
			if (lead == 8'h82) rec.push_back(8'($urandom));
		end else if (lead == 8'h80) k = 2 * k + ($urandom % 2);
		repeat (k) rec.push_back(8'($urandom));
		repeat ($urandom % 3) rec.push_back(8'hff);
		send();
	endtask : rand_rec
	always @(posedge clk) begin
		cyc++;
		if (!rst && out_done) chk({17'h0, out_valid}, 18'h0);
		if (in_valid && !in_ready) blocked <= 1'b1;
		if (cyc == 60000) begin
			n_mismatch++;
			finish_test();
		end
	end
	initial begin
		void'($urandom(32'hab8c));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		rec = '{8'h81, 8'h05, 8'h13, 8'h53, 8'h95, 8'ha6, 8'h41, 8'hff, 8'hff};
		send();
		rec = '{8'h82, 8'h05, 8'h05, 8'h30, 8'h2d, 8'h82, 8'hd3, 8'h2d, 8'h31};
		send();
		rec = '{8'h80, 8'h12, 8'h34, 8'h56};
		send();
		rec = '{8'h80, 8'h00, 8'h41, 8'hff, 8'hff, 8'hff};
		send();
		rec = '{8'h81, 8'h00, 8'h20, 8'h41};
		send();
		rec = '{8'h82, 8'h02, 8'hff, 8'hf0, 8'hff, 8'h80, 8'h33};
		send();
		rec = '{8'h41, 8'h80, 8'hff};
		send();
		drain("corners");
		partner.stall_pct = 70;
		repeat (40) rand_rec();
		drain("random_stall");
		chk({17'h0, blocked}, 18'h1);
		partner.stall_pct = 0;
		repeat (30) rand_rec();
		drain("random_fast");
		finish_test();
	end
endmodule : test_alpha_field_ucs2_decoder
`default_nettype wire
